// ===== fbd_datapath.sv
// Purpose: 64-bit float datapath of sixteen slices with start latch
// Assumes: the host microsequencer shares I_CORE_CLK
// Notes: bit 0 is the low bit of byte 7, bit 63 the top of byte 0
//
// Notes on behaviour
// - function field picks one of eight ALU operations
// - R from RAM A, bus or zero; S from Q/A/B or zero
// - carry ignored in logic; adds one in arithmetic
// - arithmetic codes give add/pass/decrement/complement/subtract
// - destination routes result to Q, RAM or output
// - slices give generate, propagate, overflow and zero
// - two-level carry look-ahead over all sixty-four bits
// - working register loads, holds, shifts either way
// - rotate wraps departing bit; shift inserts new bit
// - left shift inserts zero; right inserts selectable bit
// - single divide inserts quotient at bit 36
// - double divide inserts at bit 4, crossing 35
// - multiply examines bit 40 or 8 each step
// - zero flags combined for fraction and exponent
// - signs from bit 63 and bit 7
// - entry address sets active latch enabling loads
// - this 48-bit slice joins host slice per address
// - sixteen-word RAM, write at B address
// - source codes select the eight operand pairs
`timescale 1ns/100ps
`default_nettype none
module fbd_datapath
  import fbd_pkg::*;
#(
  parameter int SLICES = 16
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  input wire logic [10:0] I_MICROPROGRAM_ADDRESS,
  input wire logic [47:0] I_CONTROL_WORD,
  input wire logic [63:0] I_OPERAND_BUS,
  output logic [63:0] O_Y,
  output logic O_FRACTION_ZERO,
  output logic O_EXPONENT_ZERO,
  output logic O_FRACTION_SIGN,
  output logic O_EXPONENT_SIGN,
  output logic O_CARRY_OUT,
  output logic O_OVERFLOW_OUT,
  output logic O_MULT_LSB,
  output logic O_FLOAT_ACTIVE
);

  // ==========================================================
  // state
  typedef struct packed {
    logic active;
    logic exec;
    logic [47:0] cw;
    logic [63:0] y;
    logic fz;
    logic ez;
    logic fs;
    logic es;
    logic cout;
    logic overflow_out;
    logic mlsb;
  } fbd_top_st_type;

  fbd_top_st_type st, next_st;

  if (SLICES != 16) begin : g_bad_width
    $error("datapath is built for sixteen slices only");
  end

  // ==========================================================
  // decoded fields of the latched word
  fbd_src_type src;
  fbd_func_type func;
  fbd_dest_type dest;
  logic [3:0] a_addr, b_addr, sect;
  logic cin, ins_one, rot, div, dbl, entry;

  assign src = fbd_src_type'(st.cw[CW_SRC +: 3]);
  assign func = fbd_func_type'(st.cw[CW_FUNC +: 3]);
  assign dest = fbd_dest_type'(st.cw[CW_DEST +: 3]);
  assign a_addr = st.cw[CW_AADR +: 4];
  assign b_addr = st.cw[CW_BADR +: 4];
  assign sect = st.cw[CW_SECT +: 4];
  assign cin = st.cw[CW_CIN];
  assign ins_one = st.cw[CW_ONE];
  assign rot = st.cw[CW_ROT];
  assign div = st.cw[CW_DIV];
  assign dbl = st.cw[CW_DBL];

  // the host must drive the entry code first
  assign entry = (I_MICROPROGRAM_ADDRESS == ENTRY_UADDR);

  // ==========================================================
  // slice array and shift lines
  logic [63:0] f_all, y_all, q_all;
  logic [15:0] g, p, overflow_out, zero, c;
  logic [15:0] rl_in, rm_in, ql_in, qm_in;
  logic [4:0] sc;
  logic [3:0] sg, sp;

  // carries of a four-way look-ahead generator
  function automatic logic [4:0] fbd_la(
    input logic [3:0] gi,
    input logic [3:0] pi,
    input logic ci
  );
    logic [4:0] cc;
    cc = {4'h0, ci};
    for (int k = 0; k < 4; k++) begin
      cc[k + 1] = gi[k] | (pi[k] & cc[k]);
    end
    return cc;
  endfunction : fbd_la

  for (genvar s = 0; s < 4; s++) begin : g_sector
    logic [4:0] sl;
    logic [4:0] gg;
    assign gg = fbd_la(g[4*s +: 4], p[4*s +: 4], 1'b0);
    assign sg[s] = gg[4];
    assign sp[s] = &p[4*s +: 4];
    assign sl = fbd_la(g[4*s +: 4], p[4*s +: 4], sc[s]);
    assign c[4*s +: 4] = sl[3:0];
  end

  assign sc = fbd_la(sg, sp, cin);

  for (genvar i = 0; i < 16; i++) begin : g_slice
    if (i == 0) begin : g_lsb
      // left shift fills zero, rotate wraps the top bit
      assign rl_in[i] = rot & f_all[63];
      assign ql_in[i] = rot & q_all[63];
    end else if (i == DOUBLE_QBIT / 4) begin : g_dq
      assign rl_in[i] = f_all[4*i - 1];
      assign ql_in[i] = (div & dbl) ? sc[4] : q_all[4*i - 1];
    end else if (i == SINGLE_QBIT / 4) begin : g_sq
      assign rl_in[i] = f_all[4*i - 1];
      assign ql_in[i] = (div & ~dbl) ? sc[4] : q_all[4*i - 1];
    end else begin : g_mid
      assign rl_in[i] = f_all[4*i - 1];
      assign ql_in[i] = q_all[4*i - 1];
    end
    if (i == 15) begin : g_msb
      assign rm_in[i] = rot ? f_all[0] : ins_one;
      assign qm_in[i] = rot ? q_all[0] : ins_one;
    end else begin : g_low
      assign rm_in[i] = f_all[4*i + 4];
      assign qm_in[i] = q_all[4*i + 4];
    end

    fbd_slice u_slice (
      .i_clk(I_CORE_CLK),
      .i_resetn(I_RESETN),
      .i_ce(I_CE),
      .i_we(st.exec & sect[i / 4]),
      .i_src(src),
      .i_func(func),
      .i_dest(dest),
      .i_a_addr(a_addr),
      .i_b_addr(b_addr),
      .i_d(I_OPERAND_BUS[4*i +: 4]),
      .i_cin(c[i]),
      .i_ram_lsb_in(rl_in[i]),
      .i_ram_msb_in(rm_in[i]),
      .i_q_lsb_in(ql_in[i]),
      .i_q_msb_in(qm_in[i]),
      .o_f(f_all[4*i +: 4]),
      .o_y(y_all[4*i +: 4]),
      .o_q(q_all[4*i +: 4]),
      .o_g(g[i]),
      .o_p(p[i]),
      .o_ovr(overflow_out[i]),
      .o_zero(zero[i])
    );
  end

  // ==========================================================
  // start latch, control latch and status capture
  always_comb begin
    next_st = st;
    // control words load only once the entry code is seen
    if (st.active || entry) begin
      next_st.cw = I_CONTROL_WORD;
      next_st.active = ~I_CONTROL_WORD[CW_DONE];
    end
    next_st.exec = st.active | entry;
    if (st.exec && dest != DST_NOP) begin
      next_st.y = y_all;
    end
    // status follows the executed word only, so idle cycles cannot
    // overwrite it with results of stale operands
    if (st.exec) begin
      next_st.ez = &zero[EXP_SLICES - 1:0];
      next_st.fz = &zero[15:EXP_SLICES];
      next_st.es = f_all[7];
      next_st.fs = f_all[63];
      next_st.cout = sc[4];
      next_st.overflow_out = overflow_out[15];
      next_st.mlsb = dbl ? q_all[DOUBLE_MLSB] : q_all[SINGLE_MLSB];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st <= '0;
    end else if (I_CE) begin
      st <= next_st;
    end
  end

  assign O_Y = st.y;
  assign O_FRACTION_ZERO = st.fz;
  assign O_EXPONENT_ZERO = st.ez;
  assign O_FRACTION_SIGN = st.fs;
  assign O_EXPONENT_SIGN = st.es;
  assign O_CARRY_OUT = st.cout;
  assign O_OVERFLOW_OUT = st.overflow_out;
  assign O_MULT_LSB = st.mlsb;
  assign O_FLOAT_ACTIVE = st.active;

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESETN);

  logic full_run;
  assign full_run = st.exec & (sect == 4'hf) & I_CE;

  sequence s_entry;
    I_CE && entry && !I_CONTROL_WORD[CW_DONE];
  endsequence

  sequence s_run;
    I_CE ##1 st.exec;
  endsequence

  a_entry_active: assert property (
    s_entry |=> O_FLOAT_ACTIVE
  ) else $error("entry code did not set active");

  a_first_word: assert property (
    s_entry |-> s_run
  ) else $error("first control word not executed");

  a_idle_hold: assert property (
    I_CE && !st.active && !entry |=> $stable(st.cw) && !st.exec
  ) else $error("control latch moved while idle");

  a_add_sum: assert property (
    st.exec && func == FN_ADD && src == SRC_DQ
      |-> f_all == I_OPERAND_BUS + q_all + {63'h0, cin}
  ) else $error("add result wrong");

  a_sub_sum: assert property (
    st.exec && func == FN_SUBR && src == SRC_DQ
      |-> f_all == q_all + ~I_OPERAND_BUS + {63'h0, cin}
  ) else $error("s minus r result wrong");

  a_logic_nocin: assert property (
    st.exec && func == FN_EXOR && src == SRC_DQ
      |-> f_all == (I_OPERAND_BUS ^ q_all)
  ) else $error("logic result depends on carry");

  a_q_rotate: assert property (
    full_run && dest == DST_RAMQU && rot && !div
      |=> q_all == {$past(q_all[62:0]), $past(q_all[63])}
  ) else $error("rotate left of q wrong");

  a_q_rshift: assert property (
    full_run && dest == DST_RAMQD && !rot
      |=> q_all == {$past(ins_one), $past(q_all[63:1])}
  ) else $error("right shift of q wrong");

  a_div_single: assert property (
    full_run && dest == DST_RAMQU && div && !dbl && !rot
      |=> q_all[SINGLE_QBIT] == $past(sc[4])
  ) else $error("single quotient bit misplaced");

  a_div_double: assert property (
    full_run && dest == DST_RAMQU && div && dbl && !rot
      |=> q_all[DOUBLE_QBIT] == $past(sc[4])
        && q_all[36] == $past(q_all[35])
  ) else $error("double quotient bit misplaced");

  a_zero_sign: assert property (
    I_CE && st.exec |=> O_EXPONENT_ZERO == ($past(f_all[7:0]) == 8'h00)
      && O_FRACTION_SIGN == $past(f_all[63])
  ) else $error("zero or sign status wrong");

endmodule : fbd_datapath
`default_nettype wire

// ===== fbd_pkg.sv
// Purpose: shared constants and types of the bit-slice datapath
// Assumes: one processor clock drives every slice
// Notes: control word fields are packed into the 48-bit store slice
package fbd_pkg;

  // ==========================================================
  // sizes and start code
  localparam int SLICE_W = 4;
  localparam int RAM_WORDS = 16;
  localparam int CW_W = 48;
  localparam int UADDR_W = 11;
  localparam logic [10:0] ENTRY_UADDR = 11'h028; // octal 050
  localparam int EXP_SLICES = 2;
  localparam int SINGLE_QBIT = 36;
  localparam int DOUBLE_QBIT = 4;
  localparam int SINGLE_MLSB = 40;
  localparam int DOUBLE_MLSB = 8;

  // ==========================================================
  // control word layout
  localparam int CW_SRC = 0;
  localparam int CW_FUNC = 3;
  localparam int CW_DEST = 6;
  localparam int CW_AADR = 9;
  localparam int CW_BADR = 13;
  localparam int CW_SECT = 17;
  localparam int CW_CIN = 21;
  localparam int CW_ONE = 22;
  localparam int CW_ROT = 23;
  localparam int CW_DIV = 24;
  localparam int CW_DBL = 25;
  localparam int CW_DONE = 47;

  // ==========================================================
  // operand, function and destination codes
  typedef enum logic [2:0] {
    SRC_AQ = 3'h0, SRC_AB = 3'h1, SRC_ZQ = 3'h2, SRC_ZB = 3'h3,
    SRC_ZA = 3'h4, SRC_DA = 3'h5, SRC_DQ = 3'h6, SRC_DZ = 3'h7
  } fbd_src_type;

  typedef enum logic [2:0] {
    FN_ADD = 3'h0, FN_SUBR = 3'h1, FN_SUBS = 3'h2, FN_OR = 3'h3,
    FN_AND = 3'h4, FN_NOTRS = 3'h5, FN_EXOR = 3'h6, FN_EXNOR = 3'h7
  } fbd_func_type;

  typedef enum logic [2:0] {
    DST_QREG = 3'h0, DST_NOP = 3'h1, DST_RAMA = 3'h2, DST_RAMF = 3'h3,
    DST_RAMQD = 3'h4, DST_RAMD = 3'h5, DST_RAMQU = 3'h6, DST_RAMU = 3'h7
  } fbd_dest_type;

  typedef struct packed {
    logic [15:0][3:0] ram;
    logic [3:0] q;
  } fbd_slice_st_type;

endpackage : fbd_pkg

// ===== fbd_slice.sv
// Purpose: one 4-bit slice: scratch ram, alu, working register
// Assumes: carry in comes from the look-ahead tree
// Notes: shift lines are wired by the parent
`timescale 1ns/100ps
`default_nettype none
module fbd_slice
  import fbd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_we,
  input wire fbd_src_type i_src,
  input wire fbd_func_type i_func,
  input wire fbd_dest_type i_dest,
  input wire logic [3:0] i_a_addr,
  input wire logic [3:0] i_b_addr,
  input wire logic [3:0] i_d,
  input wire logic i_cin,
  input wire logic i_ram_lsb_in,
  input wire logic i_ram_msb_in,
  input wire logic i_q_lsb_in,
  input wire logic i_q_msb_in,
  output logic [3:0] o_f,
  output logic [3:0] o_y,
  output logic [3:0] o_q,
  output logic o_g,
  output logic o_p,
  output logic o_ovr,
  output logic o_zero
);
  fbd_slice_st_type st, next_st;
  logic [3:0] a, b, r, s, r2, s2, g, p;
  logic [4:0] sum;
  logic [3:0] low;

  always_comb begin
    a = st.ram[i_a_addr];
    b = st.ram[i_b_addr];
    unique case (i_src)
      SRC_AQ: begin r = a; s = st.q; end
      SRC_AB: begin r = a; s = b; end
      SRC_ZQ: begin r = 4'h0; s = st.q; end
      SRC_ZB: begin r = 4'h0; s = b; end
      SRC_ZA: begin r = 4'h0; s = a; end
      SRC_DA: begin r = i_d; s = a; end
      SRC_DQ: begin r = i_d; s = st.q; end
      SRC_DZ: begin r = i_d; s = 4'h0; end
    endcase
    r2 = (i_func == FN_SUBR) ? ~r : r;
    s2 = (i_func == FN_SUBS) ? ~s : s;
    sum = {1'b0, r2} + {1'b0, s2} + {4'h0, i_cin};
    low = {1'b0, r2[2:0]} + {1'b0, s2[2:0]} + {3'h0, i_cin};
    g = r2 & s2;
    p = r2 | s2;
    unique case (i_func)
      FN_ADD, FN_SUBR, FN_SUBS: o_f = sum[3:0];
      FN_OR: o_f = r | s;
      FN_AND: o_f = r & s;
      FN_NOTRS: o_f = ~r & s;
      FN_EXOR: o_f = r ^ s;
      FN_EXNOR: o_f = ~(r ^ s);
    endcase
    o_g = g[3] | (p[3] & g[2]) | (&p[3:2] & g[1]) | (&p[3:1] & g[0]);
    o_p = &p;
    o_ovr = sum[4] ^ low[3];
    o_zero = (o_f == 4'h0);
    o_y = (i_dest == DST_RAMA) ? a : o_f;
    o_q = st.q;
    next_st = st;
    if (i_we) begin
      unique case (i_dest)
        DST_QREG: next_st.q = o_f;
        DST_NOP: next_st.q = st.q;
        DST_RAMA, DST_RAMF: next_st.ram[i_b_addr] = o_f;
        DST_RAMQD: begin
          next_st.ram[i_b_addr] = {i_ram_msb_in, o_f[3:1]};
          next_st.q = {i_q_msb_in, st.q[3:1]};
        end
        DST_RAMD: next_st.ram[i_b_addr] = {i_ram_msb_in, o_f[3:1]};
        DST_RAMQU: begin
          next_st.ram[i_b_addr] = {o_f[2:0], i_ram_lsb_in};
          next_st.q = {st.q[2:0], i_q_lsb_in};
        end
        DST_RAMU: next_st.ram[i_b_addr] = {o_f[2:0], i_ram_lsb_in};
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

endmodule : fbd_slice
`default_nettype wire

// ===== fbd_host_model.sv
// Purpose: host microsequencer model feeding words and operands
// Assumes: bench hands over one word per cycle while valid is high
// Notes: idle lines toggle so a stray load is visible
`timescale 1ns/100ps
`default_nettype none
module fbd_host_model
  import fbd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_valid,
  input wire logic i_first,
  input wire logic [47:0] i_cw,
  input wire logic [63:0] i_d,
  output logic [10:0] o_addr,
  output logic [47:0] o_cw,
  output logic [63:0] o_d
);
  typedef struct packed {
    logic [10:0] addr;
    logic [47:0] cw;
    logic [63:0] d1;
    logic v1;
    logic [63:0] d;
  } fbd_host_st_type;
  fbd_host_st_type st;
  fbd_host_st_type next_st;

  // ===========
  // sequencing
  always_comb begin
    next_st = st;
    next_st.v1 = i_valid;
    next_st.d1 = i_d;
    if (i_first) begin
      next_st.addr = ENTRY_UADDR;
    end else if (i_valid) begin
      next_st.addr = st.addr + 11'h1;
    end else begin
      next_st.addr = ~ENTRY_UADDR ^ {10'h0, st.addr[0]};
    end
    next_st.cw = i_valid ? i_cw : ~st.cw;
    // operand lags its word by one cycle, as the execute cycle needs
    next_st.d = st.v1 ? st.d1 : ~st.d;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_addr = st.addr;
  assign o_cw = st.cw;
  assign o_d = st.d;
endmodule : fbd_host_model
`default_nettype wire

// ===== tb_fbd_datapath.sv
// Purpose: self-checking bench of the float datapath
// Assumes: host model supplies address, word and operand
// Notes: expectations come from bench functions only
`timescale 1ns/100ps
`default_nettype none
module tb_fbd_datapath;
  import fbd_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b0, vld = 1'b0, first = 1'b0;
  logic [47:0] cw = 48'h0;
  logic [63:0] d = 64'h0;
  logic [10:0] addr;
  logic [47:0] hcw;
  logic [63:0] hd, y, ra, rb, rq, x, qe;
  logic fz, ez, fs, es, co, ov, ml, act, c, up, dv, dbl;
  logic [2:0] s, f;
  logic [65:0] e;
  int errors = 0, comparisons = 0;
  logic [47:0] wq[$];
  logic [63:0] dq[$];

  always #10 clk = ~clk;

  fbd_host_model i_fbd_host_model (.i_clk(clk), .i_resetn(rstn),
    .i_valid(vld), .i_first(first), .i_cw(cw), .i_d(d),
    .o_addr(addr), .o_cw(hcw), .o_d(hd));

  fbd_datapath i_fbd_datapath (.I_CORE_CLK(clk), .I_RESETN(rstn),
    .I_CE(ce), .I_MICROPROGRAM_ADDRESS(addr), .I_CONTROL_WORD(hcw),
    .I_OPERAND_BUS(hd), .O_Y(y), .O_FRACTION_ZERO(fz),
    .O_EXPONENT_ZERO(ez), .O_FRACTION_SIGN(fs), .O_EXPONENT_SIGN(es),
    .O_CARRY_OUT(co), .O_OVERFLOW_OUT(ov), .O_MULT_LSB(ml),
    .O_FLOAT_ACTIVE(act));

  // =========
  // helpers
  function automatic logic [47:0] w(logic [2:0] sr, fn, ds,
      logic [3:0] aa, bb, logic [4:0] fl, logic last);
    w = {last, 21'h0, fl, 4'hf, bb, aa, ds, fn, sr};
  endfunction : w

  // returns overflow, carry out and result
  function automatic logic [65:0] alu(logic [2:0] sr, fn, logic ci,
      logic [63:0] a, b, q, dd);
    logic [63:0] r, t, p, n;
    logic [64:0] z;
    r = sr[2] ? (sr == 3'h4 ? 64'h0 : dd) : (sr[1] ? 64'h0 : a);
    case (sr)
      3'h0, 3'h2, 3'h6: t = q;
      3'h1, 3'h3: t = b;
      3'h7: t = 64'h0;
      default: t = a;
    endcase
    p = fn == 3'h1 ? ~r : r;
    n = fn == 3'h2 ? ~t : t;
    z = {1'b0, p} + {1'b0, n} + {64'h0, ci};
    case (fn)
      3'h3: z = {1'b0, r | t};
      3'h4: z = {1'b0, r & t};
      3'h5: z = {1'b0, ~r & t};
      3'h6: z = {1'b0, r ^ t};
      3'h7: z = {1'b0, ~(r ^ t)};
      default: z = z;
    endcase
    alu = {p[63] == n[63] && z[63] != p[63], z};
  endfunction : alu

  function automatic logic [63:0] shf(logic [63:0] v, logic l, rt, one);
    if (l) begin
      shf = {v[62:0], rt & v[63]};
    end else begin
      shf = {rt ? v[0] : one, v[63:1]};
    end
  endfunction : shf

  task automatic put(input logic [47:0] wd, input logic [63:0] dd);
    wq.push_back(wd);
    dq.push_back(dd);
  endtask : put

  task automatic chk_word(input string n, input logic [63:0] ex, g);
    comparisons++;
    if (g !== ex) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, ex, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string n, input logic ex, g);
    comparisons++;
    if (g !== ex) begin
      errors++;
      $display("mismatch %s exp %b got %b", n, ex, g);
    end
  endtask : chk_bit

  // words go back to back; idle garbage afterwards must be refused
  task automatic run;
    int n;
    n = wq.size();
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      vld <= 1'b1;
      first <= (i == 0);
      cw <= wq[i];
      d <= dq[i];
      if (i == 2) begin
        #1;
        chk_bit("active latch", 1'b1, act);
      end
    end
    @(posedge clk);
    vld <= 1'b0;
    first <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk_bit("active after last", 1'b0, act);
    wq.delete();
    dq.delete();
  endtask : run

  task automatic test_done;
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // =========
  // tests
  initial begin
    ra = $urandom(28347);
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    ce <= 1'b1;
    for (int k = 0; k < 128; k++) begin
      s = k[2:0];
      f = k[5:3];
      c = k[6];
      ra = {$urandom, $urandom};
      rb = {$urandom, $urandom};
      rq = {$urandom, $urandom};
      x = {$urandom, $urandom};
      rq[7:0] = ra[7:0];
      if (k[1]) x[7:0] = ra[7:0];
      if (k[0]) x = ra;
      put(w(SRC_DZ, FN_OR, DST_QREG, 4'h0, 4'h0, 5'h0, 1'b0), rq);
      put(w(SRC_DZ, FN_OR, DST_RAMF, 4'h0, 4'h1, 5'h0, 1'b0), ra);
      put(w(SRC_DZ, FN_OR, DST_RAMF, 4'h0, 4'h2, 5'h0, 1'b0), rb);
      put(w(s, f, DST_RAMF, 4'h1, 4'h2, {4'h0, c}, 1'b1), x);
      run;
      e = alu(s, f, c, ra, rb, rq, x);
      chk_word("alu result", e[63:0], y);
      chk_bit("fraction zero", e[63:8] == 56'h0, fz);
      chk_bit("exponent zero", e[7:0] == 8'h0, ez);
      chk_bit("fraction sign", e[63], fs);
      chk_bit("exponent sign", e[7], es);
      if (f <= 3'h2) begin
        chk_bit("carry out", e[64], co);
        chk_bit("overflow", e[65], ov);
      end
    end
    for (int k = 0; k < 16; k++) begin
      up = k[0];
      dv = k[3] & k[0];
      dbl = k[3] ^ k[1];
      ra = {$urandom, $urandom};
      rq = {$urandom, $urandom};
      x = {$urandom, $urandom};
      put(w(SRC_DZ, FN_OR, DST_QREG, 4'h0, 4'h0, 5'h0, 1'b0), rq);
      put(w(SRC_DZ, FN_OR, DST_RAMF, 4'h0, 4'h1, 5'h0, 1'b0), ra);
      put(w(SRC_DA, FN_ADD, up ? DST_RAMQU : DST_RAMQD, 4'h1, 4'h5,
        {dbl, dv, k[1], k[2], 1'b0}, 1'b0), x);
      put(w(SRC_ZQ, FN_OR, DST_RAMF, 4'h0, 4'h6, {dbl, 4'h0}, 1'b1), x);
      run;
      e = alu(SRC_DA, FN_ADD, 1'b0, ra, 64'h0, 64'h0, x);
      qe = shf(rq, up, k[1], k[2]);
      if (dv) begin
        if (dbl) qe[4] = e[64];
        else qe[36] = e[64];
      end
      chk_word("working register", qe, y);
      chk_bit("multiplier lsb", dbl ? qe[8] : qe[40], ml);
      put(w(SRC_ZA, FN_OR, DST_RAMF, 4'h5, 4'h6, 5'h0, 1'b1), x);
      run;
      chk_word("shifted ram", shf(e[63:0], up, k[1], k[2]), y);
    end
    test_done;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end
endmodule : tb_fbd_datapath
`default_nettype wire
